// file: rtl/awd_adc_window_detector.sv
// converter sequencing, result registers and window detector
`default_nettype none
// What this block does
// - the less-than limit low byte is a read/write byte register reset to zero.
// - single-ended results compare as 10-bit unsigned numbers.
// - with less-than above greater-than, a match needs the result strictly between them.
// - otherwise a match needs the result below less-than or above greater-than.
// - differential results compare as 10-bit signed numbers.
// - a right-justified all-ones limit means minus one in differential mode.
// - left-justified results compare the same way against left-justified limits.
// - each conversion lasts at least ten conversion clocks before its result appears.
// - the window match flag sits at bit 3 of the control register and is sticky.
// - right-justified high byte bits 7 to 2 copy bit 1.
module awd_adc_window_detector (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        ext_start,
  input  wire logic        differential_select,
  input  wire logic [9:0]  sample_value,
  output logic             window_match_flag,
  output logic             conv_done,
  output logic             conv_busy
);
  // ****************************************
  // register decode
  // ****************************************
  logic [7:0] less_than_limit_low_q;
  logic [7:0] less_than_limit_high_q;
  logic [7:0] greater_than_limit_low_q;
  logic [7:0] greater_than_limit_high_q;
  logic [awd_pkg::SC_W-1:0] sar_div_q;
  logic       left_justify_select_q;
  logic       en_q;
  logic       tm_q;
  logic [awd_pkg::CM_W-1:0] cm_q;
  logic [7:0] result_high_byte_q;
  logic [7:0] result_low_byte_q;
  logic [9:0] sample_q;
  awd_pkg::awd_state_type state_q;
  logic [awd_pkg::STEP_W-1:0] step_q;
  logic [awd_pkg::SC_W-1:0]   div_cnt_q;
  logic       result_write;
  logic       cmp_match;
  logic [15:0] new_word;

  wire ctrl_wr = sfr_wr && (sfr_addr == awd_pkg::ADDR_CTRL);
  wire cfg_wr  = sfr_wr && (sfr_addr == awd_pkg::ADDR_CFG);

  // justify a raw code into the 16-bit result word
  function automatic logic [15:0] justify(input logic [9:0] d, input logic lj);
    justify = lj ? {d, {awd_pkg::PAD_W{1'b0}}} : {{awd_pkg::PAD_W{d[9]}}, d};
  endfunction

  // limit registers, plain storage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      less_than_limit_low_q     <= awd_pkg::RST_LT;
      less_than_limit_high_q    <= awd_pkg::RST_LT;
      greater_than_limit_low_q  <= awd_pkg::RST_GT;
      greater_than_limit_high_q <= awd_pkg::RST_GT;
    end else if (sfr_wr) begin
      if (sfr_addr == awd_pkg::ADDR_LTL) less_than_limit_low_q <= sfr_wdata;
      if (sfr_addr == awd_pkg::ADDR_LTH) less_than_limit_high_q <= sfr_wdata;
      if (sfr_addr == awd_pkg::ADDR_GTL) greater_than_limit_low_q <= sfr_wdata;
      if (sfr_addr == awd_pkg::ADDR_GTH) greater_than_limit_high_q <= sfr_wdata;
    end
  end

  // configuration: clock divider and justification
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sar_div_q             <= awd_pkg::RST_CFG[7:awd_pkg::CFG_SC_LSB];
      left_justify_select_q <= awd_pkg::RST_CFG[awd_pkg::CFG_LJST];
    end else if (cfg_wr) begin
      sar_div_q             <= sfr_wdata[7:awd_pkg::CFG_SC_LSB];
      left_justify_select_q <= sfr_wdata[awd_pkg::CFG_LJST];
    end
  end

  // control fields that only software changes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
      tm_q <= 1'b0;
      cm_q <= awd_pkg::CM_SOFT;
    end else if (ctrl_wr) begin
      en_q <= sfr_wdata[awd_pkg::CTRL_EN];
      tm_q <= sfr_wdata[awd_pkg::CTRL_TM];
      cm_q <= sfr_wdata[awd_pkg::CM_W-1:0];
    end
  end

  // ****************************************
  // conversion sequencing
  // ****************************************
  // busy write starts only in software mode; other modes use the trigger pin
  wire soft_start = ctrl_wr && sfr_wdata[awd_pkg::CTRL_BUSY] && (cm_q == awd_pkg::CM_SOFT);
  wire hw_start   = (cm_q != awd_pkg::CM_SOFT) && ext_start;
  wire start_conv = en_q && (state_q == awd_pkg::ST_IDLE) && (soft_start || hw_start);
  wire sar_tick   = (state_q != awd_pkg::ST_IDLE) && (div_cnt_q == sar_div_q);

  // conversion clock as an enable: one tick every divider+1 cycles
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= '0;
    end else if (state_q == awd_pkg::ST_IDLE || sar_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // state machine; the sample is held so a moving input cannot tear the result
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q  <= awd_pkg::ST_IDLE;
      step_q   <= '0;
      sample_q <= '0;
    end else begin
      case (state_q)
        awd_pkg::ST_IDLE: begin
          step_q <= '0;
          if (start_conv) begin
            sample_q <= sample_value;
            state_q  <= tm_q ? awd_pkg::ST_TRACK : awd_pkg::ST_CONVERT;
          end
        end
        awd_pkg::ST_TRACK: begin
          if (sar_tick) begin
            if (step_q == awd_pkg::STEP_W'(awd_pkg::TRACK_SAR_CLOCKS - 1)) begin
              step_q  <= '0;
              state_q <= awd_pkg::ST_CONVERT;
            end else begin
              step_q <= step_q + 1'b1;
            end
          end
        end
        awd_pkg::ST_CONVERT: begin
          if (sar_tick) begin
            if (step_q == awd_pkg::STEP_W'(awd_pkg::CONV_SAR_CLOCKS - 1)) begin
              step_q  <= '0;
              state_q <= awd_pkg::ST_IDLE;
            end else begin
              step_q <= step_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= awd_pkg::ST_IDLE;
          step_q  <= '0;
        end
      endcase
    end
  end

  assign result_write = (state_q == awd_pkg::ST_CONVERT) && sar_tick
                     && (step_q == awd_pkg::STEP_W'(awd_pkg::CONV_SAR_CLOCKS - 1));
  assign new_word = justify(sample_q, left_justify_select_q);

  // ****************************************
  // result and window decision
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_high_byte_q <= awd_pkg::RST_BYTE;
      result_low_byte_q  <= awd_pkg::RST_BYTE;
    end else if (result_write) begin
      result_high_byte_q <= new_word[15:8];
      result_low_byte_q  <= new_word[7:0];
    end
  end

  awd_window_compare u_cmp (
    .word         (new_word),
    .gt_limit     ({greater_than_limit_high_q, greater_than_limit_low_q}),
    .lt_limit     ({less_than_limit_high_q, less_than_limit_low_q}),
    .signed_mode  (differential_select),
    .left_justify (left_justify_select_q),
    .match        (cmp_match)
  );

  // sticky flags: a hardware set beats a software clear in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      window_match_flag <= 1'b0;
      conv_done         <= 1'b0;
    end else begin
      window_match_flag <= (result_write && cmp_match)
                        || (ctrl_wr ? sfr_wdata[awd_pkg::CTRL_WIN] : window_match_flag);
      conv_done <= result_write
                || (ctrl_wr ? sfr_wdata[awd_pkg::CTRL_DONE] : conv_done);
    end
  end

  // busy mirrors the sequencer, registered for a clean output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      conv_busy <= 1'b0;
    end else begin
      conv_busy <= start_conv || ((state_q != awd_pkg::ST_IDLE) && !result_write);
    end
  end

  // read data, one cycle after the read strobe; unknown addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= awd_pkg::RST_BYTE;
    end else if (sfr_rd) begin
      case (sfr_addr)
        awd_pkg::ADDR_LTL:  sfr_rdata <= less_than_limit_low_q;
        awd_pkg::ADDR_LTH:  sfr_rdata <= less_than_limit_high_q;
        awd_pkg::ADDR_GTL:  sfr_rdata <= greater_than_limit_low_q;
        awd_pkg::ADDR_GTH:  sfr_rdata <= greater_than_limit_high_q;
        awd_pkg::ADDR_CFG:  sfr_rdata <= {sar_div_q, left_justify_select_q, 2'b00};
        awd_pkg::ADDR_RESH: sfr_rdata <= result_high_byte_q;
        awd_pkg::ADDR_RESL: sfr_rdata <= result_low_byte_q;
        awd_pkg::ADDR_CTRL: sfr_rdata <= {en_q, tm_q, conv_done, conv_busy,
                                          window_match_flag, cm_q};
        default:            sfr_rdata <= awd_pkg::RST_BYTE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire [15:0] gt_w = {greater_than_limit_high_q, greater_than_limit_low_q};
  wire [15:0] lt_w = {less_than_limit_high_q, less_than_limit_low_q};
  sequence s_begin;
    start_conv && !tm_q;
  endsequence
  sequence s_rj_write(logic diff);
    result_write && !left_justify_select_q && (differential_select == diff);
  endsequence
  property p_ltl_store;
    sfr_wr && sfr_addr == awd_pkg::ADDR_LTL |=> less_than_limit_low_q == $past(sfr_wdata);
  endproperty
  a_ltl_store: assert property (p_ltl_store) else $error("limit low byte not stored");

  property p_se_inside;
    s_rj_write(1'b0) and (lt_w > gt_w && {6'h00, sample_q} > gt_w && {6'h00, sample_q} < lt_w)
      |=> window_match_flag;
  endproperty
  a_se_inside: assert property (p_se_inside) else $error("inside match missed");

  property p_se_outside;
    s_rj_write(1'b0) and (lt_w <= gt_w && {6'h00, sample_q} < lt_w) |=> window_match_flag;
  endproperty
  a_se_outside: assert property (p_se_outside) else $error("outside match missed");

  property p_diff_neg;
    s_rj_write(1'b1) and (gt_w == 16'hFFFF && lt_w == 16'h0040 && sample_q[9]
      && !window_match_flag && !ctrl_wr) |=> !window_match_flag;
  endproperty
  a_diff_neg: assert property (p_diff_neg) else $error("negative code matched");

  property p_diff_window;
    s_rj_write(1'b1) and (gt_w == 16'hFFFF && lt_w == 16'h0040 && sample_q < 10'h040)
      |=> window_match_flag;
  endproperty
  a_diff_window: assert property (p_diff_window) else $error("0..63 not matched");

  property p_lj_inside;
    result_write && left_justify_select_q && !differential_select && lt_w > gt_w
      && {sample_q, 6'h00} > gt_w && {sample_q, 6'h00} < lt_w |=> window_match_flag;
  endproperty
  a_lj_inside: assert property (p_lj_inside) else $error("left inside missed");

  property p_conv_len;
    s_begin |=> conv_busy [*8] ##1 conv_busy ##1 conv_busy;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");

  property p_win_sticky;
    window_match_flag && !ctrl_wr |=> window_match_flag;
  endproperty
  a_win_sticky: assert property (p_win_sticky) else $error("match flag dropped");

  property p_sign_fill;
    result_write && !left_justify_select_q |=> result_high_byte_q[7:2] == {6{result_high_byte_q[1]}};
  endproperty
  a_sign_fill: assert property (p_sign_fill) else $error("high byte not sign filled");

  property p_set_cause;
    !window_match_flag ##1 window_match_flag |-> $past(result_write) || $past(ctrl_wr);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("match set without result");
endmodule
`default_nettype wire

// file: rtl/awd_pkg.sv
// constants, addresses and types of the converter window detector
`default_nettype none
package awd_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_LTL  = 8'hC5;
  localparam logic [7:0] ADDR_LTH  = 8'hC6;
  localparam logic [7:0] ADDR_GTL  = 8'hC3;
  localparam logic [7:0] ADDR_GTH  = 8'hC4;
  localparam logic [7:0] ADDR_CTRL = 8'hE8;
  localparam logic [7:0] ADDR_CFG  = 8'hBC;
  localparam logic [7:0] ADDR_RESH = 8'hBE;
  localparam logic [7:0] ADDR_RESL = 8'hBD;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_LT   = 8'h00;
  localparam logic [7:0] RST_GT   = 8'hFF;
  localparam logic [7:0] RST_CFG  = 8'hF8;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_EN   = 7;
  localparam int CTRL_TM   = 6;
  localparam int CTRL_DONE = 5;
  localparam int CTRL_BUSY = 4;
  localparam int CTRL_WIN  = 3;
  localparam int CM_W      = 3;
  localparam int CFG_SC_LSB = 3;
  localparam int SC_W      = 5;
  localparam int CFG_LJST  = 2;
  localparam int DATA_W    = 10;
  localparam int PAD_W     = 6;
  localparam logic [CM_W-1:0] CM_SOFT = 3'h0;

  // ****************************************
  // timing in conversion clocks
  // ****************************************
  localparam int CONV_SAR_CLOCKS  = 10;
  localparam int TRACK_SAR_CLOCKS = 3;
  localparam int STEP_W           = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONVERT} awd_state_type;
endpackage
`default_nettype wire

// file: rtl/awd_window_compare.sv
// window decision on one justified result word
`default_nettype none
module awd_window_compare (
  input  wire logic [15:0] word,
  input  wire logic [15:0] gt_limit,
  input  wire logic [15:0] lt_limit,
  input  wire logic        signed_mode,
  input  wire logic        left_justify,
  output logic             match
);
  // ****************************************
  // widen to 17 bits so one signed compare serves both modes
  // ****************************************
  function automatic logic signed [16:0] widen(input logic [15:0] v, input logic sgn);
    widen = sgn ? {v[15], v} : {1'b0, v};
  endfunction

  logic signed [16:0] w_s;
  logic signed [16:0] gt_s;
  logic signed [16:0] lt_s;

  // unsigned right-justified words carry sign fill above bit 9; drop it
  always_comb begin
    if (!signed_mode && !left_justify) begin
      w_s = {7'h00, word[awd_pkg::DATA_W-1:0]};
    end else begin
      w_s = widen(word, signed_mode);
    end
    gt_s = widen(gt_limit, signed_mode);
    lt_s = widen(lt_limit, signed_mode);
  end

  // limit order picks inside or outside detection
  always_comb begin
    if (lt_s > gt_s) begin
      match = (w_s > gt_s) && (w_s < lt_s);
    end else begin
      match = (w_s < lt_s) || (w_s > gt_s);
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_adc_window_detector.sv
// self-checking bench of the converter window detector
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_adc_window_detector;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and bookkeeping
  // ****************************************
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic       ext_start = 1'b0;
  logic       differential_select = 1'b0;
  logic [9:0] sample_value = 10'h000;
  logic       window_match_flag;
  logic       conv_done;
  logic       conv_busy;
  int         n_fail = 0;
  int         total_checks = 0;
  int         seed = 32'h5bb1_a5cc;
  int         n_busy;
  // slowest divider: keeps the conversion clock as low as the field allows at 100 MHz
  localparam logic [4:0] SLOW_DIV = 5'h1F;
  logic [7:0] exp_q[$];
  string      name_q[$];
  logic       rd_seen = 1'b0;
  logic [7:0] mon_e;
  string      mon_n;

  awd_adc_window_detector u_dut (
    .clock               (clock),
    .rstn                (rstn),
    .sfr_addr            (sfr_addr),
    .sfr_wr              (sfr_wr),
    .sfr_wdata           (sfr_wdata),
    .sfr_rd              (sfr_rd),
    .sfr_rdata           (sfr_rdata),
    .ext_start           (ext_start),
    .differential_select (differential_select),
    .sample_value        (sample_value),
    .window_match_flag   (window_match_flag),
    .conv_done           (conv_done),
    .conv_busy           (conv_busy)
  );

  // 100 MHz clock
  always #5 clock = ~clock;

  // read data lands one cycle after the strobe; oldest note first
  always @(posedge clock) begin
    if (rd_seen && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_n = name_q.pop_front();
      `CHK(mon_n, mon_e, sfr_rdata)
    end
    rd_seen <= sfr_rd;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  // one-cycle write strobe, idle cycle between writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
  endtask

  // read strobe plus expected note for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clock);
    sfr_rd   <= 1'b0;
  endtask

  // count busy cycles until the done flag shows; bounded so a hang cannot stall here
  task automatic wait_done(output int n);
    n = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clock);
      if (conv_done === 1'b1) break;
      if (conv_busy === 1'b1) n++;
    end
  endtask

  // window decision worked out from the limits; equal limits count as outside
  function automatic logic exp_match(input logic d, input logic lj, input logic [15:0] g,
                                     input logic [15:0] l, input logic [9:0] c);
    logic [15:0] w;
    w = lj ? {c, 6'h00} : (d ? {{6{c[9]}}, c} : {6'h00, c});
    if (d) begin
      if ($signed(l) > $signed(g)) return $signed(w) > $signed(g) && $signed(w) < $signed(l);
      return $signed(w) < $signed(l) || $signed(w) > $signed(g);
    end
    return (l > g) ? (w > g && w < l) : (w < l || w > g);
  endfunction

  // one software-started conversion, then flag, timing and result bytes
  task automatic conv(input logic d, input logic lj, input logic [4:0] dv,
                      input logic [15:0] g, input logic [15:0] l, input logic [9:0] c);
    int   n;
    logic e;
    e = exp_match(d, lj, g, l, c);
    @(posedge clock);
    differential_select <= d;
    sample_value        <= c;
    wr(awd_pkg::ADDR_CFG, {dv, lj, 2'b00});
    wr(awd_pkg::ADDR_GTH, g[15:8]);
    wr(awd_pkg::ADDR_GTL, g[7:0]);
    wr(awd_pkg::ADDR_LTH, l[15:8]);
    wr(awd_pkg::ADDR_LTL, l[7:0]);
    wr(awd_pkg::ADDR_CTRL, 8'h80);
    wr(awd_pkg::ADDR_CTRL, 8'h90);
    wait_done(n);
    `CHK("busy_cycles", 10 * (dv + 1), n)
    `CHK("window_match_flag", e, window_match_flag)
    rd(awd_pkg::ADDR_RESH, lj ? c[9:2] : {{6{c[9]}}, c[9:8]}, "result_high");
    rd(awd_pkg::ADDR_RESL, lj ? {c[1:0], 6'h00} : c[7:0], "result_low");
  endtask

  // verdict in one place
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(awd_pkg::ADDR_LTL, 8'h00, "lt_low_reset");
    rd(awd_pkg::ADDR_GTH, 8'hFF, "gt_high_reset");
    rd(awd_pkg::ADDR_CFG, 8'hF8, "cfg_reset");
    rd(8'h01, 8'h00, "unmapped");
    wr(awd_pkg::ADDR_LTL, 8'hA5);
    rd(awd_pkg::ADDR_LTL, 8'hA5, "lt_low_rw");
    wr(awd_pkg::ADDR_RESH, 8'h55);
    rd(awd_pkg::ADDR_RESH, 8'h00, "result_read_only");
    // start while disabled is ignored
    wr(awd_pkg::ADDR_CTRL, 8'h10);
    repeat (3) @(posedge clock);
    `CHK("busy_disabled", 1'b0, conv_busy)
    $display("test registers done");
    // inside and outside, boundaries, both formats and signedness
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0040, 16'h0080, 10'h041);
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0040, 16'h0080, 10'h040);
    conv(1'b0, 1'b0, 5'd30, 16'h0040, 16'h0080, 10'h080);
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0080, 16'h0040, 10'h03F);
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0080, 16'h0040, 10'h040);
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0080, 16'h0040, 10'h081);
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0050, 16'h0050, 10'h050);
    conv(1'b1, 1'b0, SLOW_DIV, 16'hFFFF, 16'h0040, 10'h000);
    conv(1'b1, 1'b0, SLOW_DIV, 16'hFFFF, 16'h0040, 10'h3FF);
    conv(1'b1, 1'b0, SLOW_DIV, 16'hFFFF, 16'h0040, 10'h03F);
    conv(1'b1, 1'b0, SLOW_DIV, 16'hFFFF, 16'h0040, 10'h040);
    conv(1'b1, 1'b0, SLOW_DIV, 16'h0040, 16'hFFFF, 10'h3FE);
    conv(1'b0, 1'b1, SLOW_DIV, 16'h1000, 16'h2000, 10'h041);
    conv(1'b1, 1'b1, SLOW_DIV, 16'hFFC0, 16'h1000, 10'h3FF);
    conv(1'b1, 1'b1, SLOW_DIV, 16'hFFC0, 16'h1000, 10'h000);
    $display("test window cases done");
    repeat (6) conv(1'b0, 1'b0, SLOW_DIV, 16'h0040, 16'h0080, 10'($random(seed)));
    $display("test random codes done");
    // flag stays set through a later miss until software clears it
    conv(1'b0, 1'b0, SLOW_DIV, 16'h0040, 16'h0080, 10'h050);
    @(posedge clock);
    sample_value <= 10'h3F0;
    wr(awd_pkg::ADDR_CTRL, 8'hB8);
    repeat (330) @(posedge clock);
    `CHK("match_sticky", 1'b1, window_match_flag)
    rd(awd_pkg::ADDR_CTRL, 8'hA8, "ctrl_flags");
    wr(awd_pkg::ADDR_CTRL, 8'h80);
    rd(awd_pkg::ADDR_CTRL, 8'h80, "ctrl_cleared");
    $display("test sticky flag done");
    // trigger pin start with tracking: three extra conversion clocks before the result
    wr(awd_pkg::ADDR_CTRL, 8'hC1);
    @(posedge clock);
    sample_value <= 10'h060;
    ext_start    <= 1'b1;
    @(posedge clock);
    ext_start    <= 1'b0;
    wait_done(n_busy);
    `CHK("busy_cycles_track", 13 * (SLOW_DIV + 1), n_busy)
    `CHK("window_match_track", 1'b1, window_match_flag)
    rd(awd_pkg::ADDR_RESL, 8'h60, "result_low_track");
    $display("test trigger start done");
    repeat (3) @(posedge clock);
    wrap_up();
  end

  // hang guard, well beyond the eight thousand or so cycles the run needs
  initial begin
    #250000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
